// *** eews_defines.vh ***
// constants and rule summary for the two-wire eeprom slave write front end
// Summary of operation
// R01: SDA falling while SCL high is Start; detected at any time.
// R02: SDA rising while SCL high is Stop; ends the transfer.
// R03: SDA changes only while SCL low; high-phase changes are Start/Stop.
// R04: master starts only on idle bus and decides byte count.
// R05: receiver acknowledges by holding SDA low through ninth clock high.
// R06: no acknowledge at all while the programming cycle runs.
// R07: on reads master withholds ack; slave then releases SDA high.
// R08: control byte top four bits must match device-type code.
// R09: next three bits must match chip-select inputs, high bit first.
// R10: on type and select match, acknowledge the control byte.
// R11: control byte lowest bit: one is read, zero is write.
// R12: write takes two address bytes, high first; keeps 14 bits.
// R13: reduced package master sends the two missing select bits as zero.
// R14: pointer never carries across devices; master re-addresses.
// R15: byte write: control, ack, addr high, ack, addr low, ack, data, ack, Stop.
// R16: Stop after acked data starts self-timed write, at most 5 ms.
// R17: write-protect high: still ack, but no write cycle, accept at once.
// R18: write-protect blocks only writes; reads proceed normally.
// R19: after byte write, address counter holds written address plus one.
// R20: write-protect sampled at Stop; later changes do not matter.
// R21: on mismatch release SDA and ignore bus until next Start.
`ifndef EEWS_DEFINES_VH
`define EEWS_DEFINES_VH
`define EEWS_ADDR_W 14
`define EEWS_CTRL_TYPE_MSB 7
`define EEWS_CTRL_TYPE_LSB 4
`define EEWS_CTRL_SEL_MSB 3
`define EEWS_CTRL_SEL_LSB 1
`define EEWS_CTRL_RW_BIT 0
`define EEWS_WRITE_TIME_US 5000
`define EEWS_CLK_MHZ 40
`define EEWS_WRITE_CYCLES (`EEWS_WRITE_TIME_US * `EEWS_CLK_MHZ)
`define EEWS_ADDR_RESET 14'h0000
`endif

// *** eews_slave.v ***
// two-wire eeprom slave: framing, addressing, byte write, write cycle
`timescale 1ns/1ps
`default_nettype none
`include "eews_defines.vh"
module eews_slave #(
  parameter [3:0] DEVICE_TYPE = 4'h5, // arbitrary value, set per product
  parameter WRITE_CYCLES = `EEWS_WRITE_CYCLES
) (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_scl,
  input wire i_sda,
  input wire i_chip_select_input_low,
  input wire i_chip_select_input_mid,
  input wire i_chip_select_input_high,
  input wire i_write_protect,
  output reg o_sda_oe,
  output reg o_busy,
  output reg o_mem_we,
  output reg [`EEWS_ADDR_W-1:0] o_mem_addr,
  output reg [7:0] o_mem_data,
  output reg [`EEWS_ADDR_W-1:0] o_word_address_bits,
  output reg o_read_req
);
  // states, one-hot
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CTRL = 6'h02;
  localparam [5:0] ST_ADRH = 6'h04;
  localparam [5:0] ST_ADRL = 6'h08;
  localparam [5:0] ST_DATA = 6'h10;
  localparam [5:0] ST_RD = 6'h20;
  localparam CNT_W = 24;
  // cut to the counter width on purpose; the default fits in 24 bits
  localparam [CNT_W-1:0] WC_LAST = WRITE_CYCLES[CNT_W-1:0] - 1'b1;

  // two-flop synchronisers for every pin
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg [1:0] wp_sync_reg;
  reg [2:0] cs_meta_reg;
  reg [2:0] cs_reg;
  reg scl_d_reg;
  reg sda_d_reg;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      wp_sync_reg <= 2'h0;
      cs_meta_reg <= 3'h0;
      cs_reg <= 3'h0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      wp_sync_reg <= {wp_sync_reg[0], i_write_protect};
      cs_meta_reg <= {i_chip_select_input_high, i_chip_select_input_mid,
                      i_chip_select_input_low};
      cs_reg <= cs_meta_reg;
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  // data changes only with scl low; high-phase edges are conditions
  wire start_det = scl & scl_d_reg & sda_d_reg & ~sda; // R01 R03
  wire stop_det = scl & scl_d_reg & ~sda_d_reg & sda; // R02 R03

  reg [5:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg ack_phase_reg;
  reg ack_drive_reg;
  reg data_done_reg;
  reg [`EEWS_ADDR_W-1:0] ptr_reg;
  reg [7:0] data_reg;
  reg [CNT_W-1:0] wc_cnt_reg;
  wire [7:0] rx_byte = {shift_reg[6:0], sda};
  // type code and select bits of the complete control byte
  wire ctrl_match = (shift_reg[`EEWS_CTRL_TYPE_MSB:`EEWS_CTRL_TYPE_LSB]
                     == DEVICE_TYPE) && // R08
                    (shift_reg[`EEWS_CTRL_SEL_MSB:`EEWS_CTRL_SEL_LSB]
                     == cs_reg); // R09

  // byte framing, ack generation and command decode
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_phase_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      data_done_reg <= 1'b0;
      ptr_reg <= `EEWS_ADDR_RESET;
      data_reg <= 8'h00;
      wc_cnt_reg <= {CNT_W{1'b0}};
      o_sda_oe <= 1'b0;
      o_busy <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= `EEWS_ADDR_RESET;
      o_mem_data <= 8'h00;
      o_word_address_bits <= `EEWS_ADDR_RESET;
      o_read_req <= 1'b0;
    end else begin
      o_mem_we <= 1'b0;
      o_read_req <= 1'b0;
      // self-timed programming; counter bounds the cycle at the full time
      if (o_busy) begin
        if (wc_cnt_reg == WC_LAST) begin
          o_busy <= 1'b0; // R16
        end else begin
          wc_cnt_reg <= wc_cnt_reg + 1'b1;
        end
      end
      if (start_det) begin
        // start wins anywhere, even mid-byte or after a mismatch
        state_reg <= ST_CTRL; // R01 R21
        bit_cnt_reg <= 4'h0;
        ack_phase_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
        data_done_reg <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_det) begin
        state_reg <= ST_IDLE; // R02
        o_sda_oe <= 1'b0; // R07
        ack_drive_reg <= 1'b0;
        // protect level is taken here only; later changes do not matter
        if (data_done_reg && !wp_sync_reg[1] && !o_busy) begin // R17 R20
          o_busy <= 1'b1; // R15 R16
          wc_cnt_reg <= {CNT_W{1'b0}};
          o_mem_we <= 1'b1;
          o_mem_addr <= ptr_reg;
          o_mem_data <= data_reg;
          ptr_reg <= ptr_reg + 1'b1; // R19
        end
        data_done_reg <= 1'b0;
      end else if (state_reg != ST_IDLE) begin
        if (scl_rise && !ack_phase_reg) begin
          shift_reg <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (scl_fall && !ack_phase_reg && bit_cnt_reg == 4'h8) begin
          // byte complete: decide on ack for the ninth clock
          bit_cnt_reg <= 4'h0;
          ack_phase_reg <= 1'b1;
          ack_drive_reg <= 1'b0;
          case (state_reg)
            ST_CTRL: begin
              if (!o_busy && ctrl_match) begin // R08 R09
                ack_drive_reg <= 1'b1; // R06 R10
                o_sda_oe <= 1'b1; // R05
                if (shift_reg[`EEWS_CTRL_RW_BIT]) begin // R11
                  state_reg <= ST_RD; // R18
                  o_read_req <= 1'b1;
                end else begin
                  state_reg <= ST_ADRH;
                end
              end else begin
                state_reg <= ST_IDLE; // R21
              end
            end
            ST_ADRH: begin
              ptr_reg[`EEWS_ADDR_W-1:8] <= shift_reg[5:0]; // R12
              ack_drive_reg <= 1'b1;
              o_sda_oe <= 1'b1; // R05
              state_reg <= ST_ADRL;
            end
            ST_ADRL: begin
              ptr_reg[7:0] <= shift_reg; // R12
              o_word_address_bits <= {ptr_reg[`EEWS_ADDR_W-1:8], shift_reg};
              ack_drive_reg <= 1'b1;
              o_sda_oe <= 1'b1; // R05
              state_reg <= ST_DATA;
            end
            ST_DATA: begin
              // only a single byte is kept; further bytes overwrite it
              data_reg <= shift_reg;
              data_done_reg <= 1'b1; // R15
              ack_drive_reg <= 1'b1;
              o_sda_oe <= 1'b1; // R05
            end
            default: begin
              // read data path lies outside this block; release the line
              state_reg <= ST_IDLE; // R07 R14
            end
          endcase
        end else if (scl_fall && ack_phase_reg) begin
          // ninth clock over: release so the master owns sda again
          ack_phase_reg <= 1'b0;
          ack_drive_reg <= 1'b0;
          o_sda_oe <= 1'b0; // R05 R07
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** eews_checker.sv ***
// timing checks on the two-wire eeprom slave ports
`timescale 1ns/1ps
`default_nettype none
module eews_checker (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_write_protect,
  input wire logic o_sda_oe,
  input wire logic o_busy,
  input wire logic o_mem_we
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // write strobe opens the busy span and stays a single pulse
  we_pulse_a: assert property (o_mem_we |=> !o_mem_we)
    else $error("write strobe too long");
  busy_cause_a: assert property ($rose(o_busy) |-> o_mem_we)
    else $error("busy without strobe");
  busy_hold_a: assert property (o_mem_we |=> o_busy[*8])
    else $error("busy too short");
  busy_mute_a: assert property (o_busy |-> !o_sda_oe)
    else $error("ack while busy");
  // the slave moves the data line only while the clock is low
  oe_rise_a: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("ack rises in clock high");
  oe_fall_a: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("ack falls in clock high");
  ack_hold_a: assert property (o_sda_oe && $rose(i_scl) |=>
    o_sda_oe[*3])
    else $error("ack not held");
  wp_block_a: assert property (o_mem_we |-> !i_write_protect)
    else $error("write while protected");
endmodule
bind eews_slave eews_checker eews_checker_i (.i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn), .i_scl(i_scl), .i_write_protect(i_write_protect),
  .o_sda_oe(o_sda_oe), .o_busy(o_busy), .o_mem_we(o_mem_we));
`default_nettype wire

// *** eews_master.sv ***
// two-wire bus master model; clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module eews_master (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial {o_scl, o_sda} = 2'b11;
  // one bit; data moves only while the clock is low
  task automatic put_bit(input logic b, output logic r);
    o_sda = b;
    #50 o_scl = 1'b1;
    #50 r = i_sda;
    #50 o_scl = 1'b0;
    #50;
  endtask
  task automatic start_cond();
    o_sda = 1'b1;
    #50 o_scl = 1'b1;
    #100 o_sda = 1'b0;
    #100 o_scl = 1'b0;
  endtask
  task automatic stop_cond();
    o_sda = 1'b0;
    #50 o_scl = 1'b1;
    #100 o_sda = 1'b1;
  endtask
  // msb first, data released on the ninth clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(b[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [3:0] TYPE = 4'h9; // arbitrary type code
  localparam logic [7:0] WR = {TYPE, 4'hA};
  logic clk, rstn, wp, scl, msda, oe, busy, we, rreq;
  logic [2:0] cs;
  logic [3:0] a;
  logic [13:0] maddr, waddr;
  logic [7:0] mdata;
  int n_fail, total_checks, n_we, n_rd;
  wire logic sda = msda & ~oe; // open drain with pull-up
  eews_master eews_master_i (.i_sda(sda), .o_scl(scl), .o_sda(msda));
  eews_slave #(.DEVICE_TYPE(TYPE), .WRITE_CYCLES(400)) eews_slave_i (
    .i_sys_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda),
    .i_chip_select_input_low(cs[0]), .i_chip_select_input_mid(cs[1]),
    .i_chip_select_input_high(cs[2]), .i_write_protect(wp),
    .o_sda_oe(oe), .o_busy(busy), .o_mem_we(we), .o_mem_addr(maddr),
    .o_mem_data(mdata), .o_word_address_bits(waddr), .o_read_req(rreq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // count strobes as they pass
  always @(posedge clk) begin
    if (we === 1'b1) n_we <= n_we + 1;
    if (rreq === 1'b1) n_rd <= n_rd + 1;
  end
  task automatic check(input string s, input logic [15:0] e, g);
    total_checks++;
    if (e !== g) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // start, n bytes from the top of w, stop, then let the stop land
  task automatic xfer(input logic [31:0] w, input int n);
    a = 4'h0;
    #3; // keep bus edges off the sampling clock edge
    eews_master_i.start_cond();
    for (int k = 0; k < n; k++)
      eews_master_i.send_byte(w[31-8*k -: 8], a[3-k]);
    eews_master_i.stop_cond();
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog; the sequence needs about 65 us
  initial begin
    #600000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {rstn, wp, cs, n_fail, total_checks, n_we, n_rd} = {5'h05, 128'h0};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    xfer({WR, 24'hFFFFA5}, 4);
    check("acks", 4'hF, a);
    check("addr", 14'h3FFF, maddr);
    check("data", 8'hA5, mdata);
    xfer({WR, 24'h0}, 1);
    check("busy ack", 4'h0, a);
    wait_idle();
    check("idle", 1'b0, busy);
    $display("test write done");
    xfer({~TYPE, 4'hA, 24'h0}, 2);
    check("type", 4'h0, a);
    for (int k = 0; k < 3; k++) begin
      xfer({TYPE, 3'b101 ^ (3'b001 << k), 1'b0, 24'h0}, 2);
      check("select", 4'h0, a);
    end
    $display("test select done");
    @(posedge clk) wp <= 1'b1;
    xfer({WR, 24'h12345A}, 4);
    check("wp acks", 4'hF, a);
    xfer({WR | 8'h01, 24'h0}, 1);
    check("read ack", 4'h8, a);
    check("strobes", 16'd1, n_we[15:0]);
    check("reads", 16'd1, n_rd[15:0]);
    $display("test protect done");
    @(posedge clk) wp <= 1'b0;
    xfer({WR, 24'h00107E}, 4);
    @(posedge clk) wp <= 1'b1;
    wait_idle();
    check("strobes", 16'd2, n_we[15:0]);
    check("addr", 14'h0010, waddr);
    check("data", 8'h7E, mdata);
    $display("test late protect done");
    @(posedge clk) begin
      wp <= 1'b0;
      cs <= 3'b100;
    end
    wait_idle();
    xfer({TYPE, 4'b1000, 24'h0}, 1);
    check("reduced ack", 4'h8, a);
    check("no strobe", 16'd2, n_we[15:0]);
    $display("test reduced select done");
    print_verdict();
  end
endmodule
`default_nettype wire
